// ### coproc_busy_null_primitive_handler.sv
// busy and null response primitive sequencer of the main processor
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "cp_prim_map.svh"

module coproc_busy_null_primitive_handler #(
  parameter int ADDR_W = 32
) (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  // software register port
  input  wire logic [3:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  // instruction start from the core
  input  wire logic                  start,
  input  wire logic                  start_cond,
  input  wire logic                  start_bkpt,
  input  wire logic [ADDR_W-1:0]     start_pc,
  input  wire logic                  trace_pending,
  input  wire logic                  int_pending,
  // coprocessor interface register transfers
  output logic                       cir_req,
  output logic                       cir_we,
  output cp_prim_pkg::cir_sel_t      cir_sel,
  output logic      [ADDR_W-1:0]     cir_wdata,
  input  wire logic                  cir_ack,
  input  wire logic [15:0]           cir_rdata,
  // interrupt servicing handshake
  output logic                       irq_svc_req,
  output logic                       irq_svc_mid,
  input  wire logic                  irq_svc_done,
  // outcomes to the core
  output logic                       restart,
  output logic                       bkpt_repeat,
  output logic                       complete,
  output logic                       cond_true,
  output logic                       trace_req,
  output logic                       other_prim,
  output logic      [15:0]           prim_word,
  output logic                       busy
);
  import cp_prim_pkg::*;

  // ==================================================================
  // elaboration check
  generate
    if (ADDR_W < 16 || ADDR_W > 32) begin : g_bad_width
      $error("ADDR_W must lie between 16 and 32");
    end
  endgenerate

  // ==================================================================
  // whole state of the sequencer
  typedef struct packed {
    seq_state_t        st;
    logic [15:0]       prim;
    logic              is_cond;
    logic              bkpt;
    logic              ret_restart;
    logic [ADDR_W-1:0] pc;
    logic              cir_req;
    logic              cir_we;
    cir_sel_t          cir_sel;
    logic [ADDR_W-1:0] cir_wdata;
    logic              irq_req;
    logic              irq_mid;
    logic              restart;
    logic              bkpt_rep;
    logic              complete;
    logic              cond_true;
    logic              trace_req;
    logic              other;
    logic              enable;
    logic [31:0]       rdata;
    logic [15:0]       rereads;
    logic              busy;
  } state_t;

  state_t s_q;
  state_t s_d;

  // primitive decode on the captured word
  logic [12:0] ptype;
  logic        is_busy;
  logic        is_null;
  logic        ca;
  logic        ia;
  logic        pf;
  logic        tf;

  assign ptype   = s_q.prim[12:0] & `CPP_TYPE_MASK;
  assign is_busy = (ptype == `CPP_BUSY_CODE);
  assign is_null = (ptype == `CPP_NULL_CODE);
  assign ca      = s_q.prim[`CPP_CA_BIT];
  assign ia      = s_q.prim[`CPP_IA_BIT];
  assign pf      = s_q.prim[`CPP_PF_BIT];
  assign tf      = s_q.prim[`CPP_TF_BIT];

  // ==================================================================
  // next state; pulses fall back to zero every cycle
  always_comb begin
    s_d           = s_q;
    s_d.restart   = 1'b0;
    s_d.bkpt_rep  = 1'b0;
    s_d.complete  = 1'b0;
    s_d.trace_req = 1'b0;
    s_d.other     = 1'b0;
    s_d.rdata     = `CPP_WORD_RST;

    // register reads answer one cycle later, unmapped reads as zero
    if (reg_rd) begin
      unique case (reg_addr)
        `CPP_OFS_CTRL:     s_d.rdata = {31'h0, s_q.enable};
        `CPP_OFS_STATUS:   s_d.rdata = {25'h0, s_q.is_cond, s_q.irq_req,
                                        s_q.cir_req, s_q.st,
                                        (s_q.st != ST_IDLE)};
        `CPP_OFS_LASTPRIM: s_d.rdata = {16'h0, s_q.prim};
        `CPP_OFS_REREADS:  s_d.rdata = {16'h0, s_q.rereads};
        default:           s_d.rdata = `CPP_WORD_RST;
      endcase
    end
    if (reg_wr && reg_addr == `CPP_OFS_CTRL) begin
      s_d.enable = reg_wdata[`CPP_CTRL_EN_BIT];
    end
    if (reg_wr && reg_addr == `CPP_OFS_REREADS) begin
      s_d.rereads = `CPP_CNT_RST;
    end

    unique case (s_q.st)
      // wait for an instruction initiation; ignored while disabled
      ST_IDLE: begin
        if (start && s_q.enable) begin
          s_d.is_cond   = start_cond;
          s_d.bkpt      = start_bkpt;
          s_d.pc        = start_pc;
          s_d.cir_req   = 1'b1;
          s_d.cir_we    = 1'b0;
          s_d.cir_sel   = SEL_RESPONSE;
          s_d.st        = ST_READ;
        end
      end
      // response register read; the 16-bit word is taken on ack
      ST_READ: begin
        if (cir_ack) begin
          s_d.prim    = cir_rdata;
          s_d.cir_req = 1'b0;
          s_d.st      = ST_DECIDE;
        end
      end
      // instruction address write carrying the F-line word address
      ST_PASSPC: begin
        if (cir_ack) begin
          s_d.cir_req              = 1'b0;
          s_d.cir_we               = 1'b0;
          s_d.prim[`CPP_PC_BIT]    = 1'b0;
          s_d.st                   = ST_DECIDE;
        end
      end
      // interrupt service in progress, then restart or reread
      ST_IRQ: begin
        if (irq_svc_done) begin
          s_d.irq_req = 1'b0;
          if (s_q.ret_restart) begin
            s_d.restart  = 1'b1;
            s_d.bkpt_rep = s_q.bkpt;
            s_d.st       = ST_IDLE;
          end else begin
            s_d.cir_req = 1'b1;
            s_d.cir_we  = 1'b0;
            s_d.cir_sel = SEL_RESPONSE;
            s_d.rereads = s_q.rereads + 16'h0001;
            s_d.st      = ST_READ;
          end
        end
      end
      // act on the captured primitive
      ST_DECIDE: begin
        if (s_q.prim[`CPP_PC_BIT] && (is_busy || is_null)) begin
          // pass pc always goes first, before any other action
          s_d.cir_req   = 1'b1;
          s_d.cir_we    = 1'b1;
          s_d.cir_sel   = SEL_INSTR_ADR;
          s_d.cir_wdata = s_q.pc;
          s_d.st        = ST_PASSPC;
        end else if (is_busy) begin
          // preinstruction frame when an interrupt waits, else restart
          if (int_pending) begin
            s_d.irq_req     = 1'b1;
            s_d.irq_mid     = 1'b0;
            s_d.ret_restart = 1'b1;
            s_d.st          = ST_IRQ;
          end else begin
            s_d.restart = 1'b1;
            s_d.st      = ST_IDLE;
          end
        end else if (is_null && ca) begin
          // same handling in both instruction categories
          if (ia && int_pending) begin
            s_d.irq_req     = 1'b1;
            s_d.irq_mid     = 1'b1;
            s_d.ret_restart = 1'b0;
            s_d.st          = ST_IRQ;
          end else begin
            s_d.cir_req = 1'b1;
            s_d.cir_we  = 1'b0;
            s_d.cir_sel = SEL_RESPONSE;
            s_d.rereads = s_q.rereads + 16'h0001;
            s_d.st      = ST_READ;
          end
        end else if (is_null && s_q.is_cond) begin
          // finished bit plays no part here
          s_d.complete  = 1'b1;
          s_d.cond_true = tf;
          s_d.st        = ST_IDLE;
        end else if (is_null && pf) begin
          s_d.complete  = 1'b1;
          s_d.trace_req = trace_pending;
          s_d.st        = ST_IDLE;
        end else if (is_null && trace_pending) begin
          // trace holds the dialogue open until a finished null
          if (ia && int_pending) begin
            s_d.irq_req     = 1'b1;
            s_d.irq_mid     = 1'b1;
            s_d.ret_restart = 1'b0;
            s_d.st          = ST_IRQ;
          end else begin
            s_d.cir_req = 1'b1;
            s_d.cir_we  = 1'b0;
            s_d.cir_sel = SEL_RESPONSE;
            s_d.rereads = s_q.rereads + 16'h0001;
            s_d.st      = ST_READ;
          end
        end else if (is_null) begin
          s_d.complete = 1'b1;
          s_d.st       = ST_IDLE;
        end else begin
          // other primitives belong to other handlers
          s_d.other = 1'b1;
          s_d.st    = ST_IDLE;
        end
      end
      default: begin
        s_d.st      = ST_IDLE;
        s_d.cir_req = 1'b0;
        s_d.irq_req = 1'b0;
      end
    endcase
    // kept in the state register so the busy output has no logic after it
    s_d.busy = (s_d.st != ST_IDLE);
  end

  // ==================================================================
  // single state register with synchronous reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q             <= '0;
      s_q.st          <= ST_IDLE;
      s_q.cir_sel     <= SEL_RESPONSE;
      s_q.prim        <= `CPP_PRIM_RST;
      s_q.enable      <= `CPP_CTRL_RST;
      s_q.rereads     <= `CPP_CNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==================================================================
  // outputs straight from the state register
  assign reg_rdata   = s_q.rdata;
  assign cir_req     = s_q.cir_req;
  assign cir_we      = s_q.cir_we;
  assign cir_sel     = s_q.cir_sel;
  assign cir_wdata   = s_q.cir_wdata;
  assign irq_svc_req = s_q.irq_req;
  assign irq_svc_mid = s_q.irq_mid;
  assign restart     = s_q.restart;
  assign bkpt_repeat = s_q.bkpt_rep;
  assign complete    = s_q.complete;
  assign cond_true   = s_q.cond_true; // held until next conditional end
  assign trace_req   = s_q.trace_req;
  assign other_prim  = s_q.other;
  assign prim_word   = s_q.prim;
  assign busy        = s_q.busy;

endmodule

// ### coproc_busy_null_primitive_handler_bench.sv
// self-checking bench for the busy and null primitive sequencer
`timescale 1ns/1ns
`include "cp_prim_map.svh"
module coproc_busy_null_primitive_handler_bench;
  import cp_prim_pkg::*;
  logic        core_clk, sys_rst, reg_wr, reg_rd, start, start_cond;
  logic        start_bkpt, trace_pending, int_pending, cir_ack, cir_req;
  logic        irq_svc_req, irq_svc_mid, irq_svc_done, restart, cir_we;
  logic        bkpt_repeat, complete, cond_true, trace_req, busy;
  logic        c, t, n, ia, ip, other_prim;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, start_pc, cir_wdata, pc_seen, rd_v;
  logic [15:0] cir_rdata, w, prim_word;
  logic [1:0]  lag;
  cir_sel_t    cir_sel;
  int          errors, comparisons, seed, cycles, mids, svcs, svc_n, mid_n;
  coproc_busy_null_primitive_handler dut_u (.core_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .start, .start_cond,
    .start_bkpt, .start_pc, .trace_pending, .int_pending, .cir_req, .cir_we,
    .cir_sel, .cir_wdata, .cir_ack, .cir_rdata, .irq_svc_req, .irq_svc_mid,
    .irq_svc_done, .restart, .bkpt_repeat, .complete, .cond_true, .trace_req,
    .other_prim, .prim_word, .busy);
  coproc_model peer_u (.core_clk, .sys_rst, .cir_req, .cir_we, .cir_sel,
    .cir_wdata, .lag, .cir_ack, .cir_rdata, .pc_seen);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ======================================================
  // interrupt service answers in one cycle; hang guard
  always @(posedge core_clk) begin
    irq_svc_done <= irq_svc_req && !irq_svc_done;
    if (irq_svc_req && irq_svc_done) begin
      svcs <= svcs + 1;
      mids <= mids + int'(irq_svc_mid);
    end
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task reg_op(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  // start one instruction, wait for its outcome pulse
  task run(input logic cond, input logic bk);
    svc_n = svcs;
    mid_n = mids;
    start <= 1'b1;
    start_cond <= cond;
    start_bkpt <= bk;
    start_pc <= $random(seed);
    @(posedge core_clk);
    start <= 1'b0;
    repeat (300) begin
      @(posedge core_clk);
      #1;
      if (complete || restart || other_prim) break;
    end
    // services counted during this instruction only
    svc_n = svcs - svc_n;
    mid_n = mids - mid_n;
  endtask
  // midinstruction services: come-again word, then trace wait word
  function automatic int exp_mids(logic c, t, ia, ip, logic [15:0] w);
    return int'(ia && ip) +
      int'(!c && t && !w[`CPP_PF_BIT] && w[`CPP_IA_BIT] && ip);
  endfunction
  task conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ======================================================
  // main sequence
  initial begin
    seed = 29115;
    sys_rst = 1'b1;
    {reg_wr, reg_rd, start, start_cond, start_bkpt, trace_pending} = '0;
    {int_pending, reg_addr, reg_wdata, start_pc, lag} = '0;
    {errors, comparisons} = '0;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    reg_op(1'b0, `CPP_OFS_CTRL, 32'h0);
    check(rd_v, 32'h1);
    reg_op(1'b0, 4'h2, 32'h0);
    check(rd_v, 32'h0);
    // a start while disabled is dropped
    reg_op(1'b1, `CPP_OFS_CTRL, 32'h0);
    @(posedge core_clk);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    @(posedge core_clk);
    #1 check(busy, 1'b0);
    reg_op(1'b1, `CPP_OFS_CTRL, 32'h1);
    // busy with and without pass-pc, with and without an interrupt
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      w = {1'b0, i[1], 1'b0, `CPP_BUSY_CODE};
      peer_u.load(w);
      int_pending <= i[0];
      lag <= 2'(i * 3);
      run(1'b0, 1'b1);
      check(restart, 1'b1);
      check(bkpt_repeat, i[0]);
      check(svc_n, i[0]);
      if (i[1]) check(pc_seen, start_pc);
    end
    // random null dialogues over both instruction kinds
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      {c, t, n, ia, ip} = 5'($random(seed));
      peer_u.load({1'b1, n, 1'b0, `CPP_NULL_CODE} | {7'h0, ia, 8'h0});
      w = {3'b000, `CPP_NULL_CODE} | (16'($random(seed)) & 16'h0103);
      peer_u.load(w);
      if (!c && t && !w[1]) peer_u.load(w | 16'h0002);
      trace_pending <= t;
      int_pending <= ip;
      lag <= 2'($random(seed));
      run(c, 1'b0);
      check(complete, 1'b1);
      if (c) check(cond_true, w[0]);
      check(trace_req, !c && t);
      check(mid_n, exp_mids(c, t, ia, ip, w));
      check(svc_n, mid_n);
      if (n) check(pc_seen, start_pc);
    end
    reg_op(1'b0, `CPP_OFS_LASTPRIM, 32'h0);
    check(rd_v[15:0], (!c && t && !w[1]) ? (w | 16'h0002) : w);
    // a primitive of another kind ends the general dialogue at once
    @(posedge core_clk);
    peer_u.load(16'h0400);
    run(1'b0, 1'b0);
    check(other_prim, 1'b1);
    check(prim_word, 32'h0000_0400);
    conclude();
  end
endmodule

// ### coproc_model.sv
// coprocessor model answering interface register transfers
`timescale 1ns/1ns
module coproc_model (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  cir_req,
  input  wire logic                  cir_we,
  input  wire cp_prim_pkg::cir_sel_t cir_sel,
  input  wire logic [31:0]           cir_wdata,
  input  wire logic [1:0]            lag,
  output logic                       cir_ack,
  output logic      [15:0]           cir_rdata,
  output logic      [31:0]           pc_seen
);
  import cp_prim_pkg::*;
  logic [15:0] word_q;
  logic [1:0]  wait_q;
  logic [15:0] queue_q[$];
  task load(input logic [15:0] w);
    queue_q.push_back(w);
  endtask
  // outside the ack cycle the data lines carry junk, never the word
  assign cir_rdata = cir_ack ? word_q : ~word_q;
  // ======================================================
  // answer after lag cycles, one word per read
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cir_ack <= 1'b0;
      wait_q <= 2'h0;
    end else if (cir_ack) cir_ack <= 1'b0;
    else if (cir_req && wait_q != lag) wait_q <= wait_q + 2'h1;
    else if (cir_req) begin
      cir_ack <= 1'b1;
      wait_q <= 2'h0;
      if (cir_we && cir_sel == SEL_INSTR_ADR) pc_seen <= cir_wdata;
      else if (!cir_we) word_q <= queue_q.pop_front();
    end
  end
endmodule

// ### cp_prim_map.svh
// register offsets, primitive field positions and reset values
`ifndef CP_PRIM_MAP_SVH
`define CP_PRIM_MAP_SVH

// ====================================================================
// software register offsets (byte addresses, one word each)
`define CPP_OFS_CTRL      4'h0
`define CPP_OFS_STATUS    4'h4
`define CPP_OFS_LASTPRIM  4'h8
`define CPP_OFS_REREADS   4'hC

// ====================================================================
// control register fields and reset value
`define CPP_CTRL_EN_BIT   0
`define CPP_CTRL_RST      1'h1

// ====================================================================
// response primitive common bits
`define CPP_CA_BIT        15
`define CPP_PC_BIT        14
`define CPP_DR_BIT        13

// ====================================================================
// null primitive option bits
`define CPP_IA_BIT        8
`define CPP_PF_BIT        1
`define CPP_TF_BIT        0

// ====================================================================
// primitive type codes, bits 12..0 after masking
`define CPP_TYPE_MASK     13'h1E00
`define CPP_BUSY_CODE     13'h0200
`define CPP_NULL_CODE     13'h0800

// ====================================================================
// reset values of datapath registers
`define CPP_PRIM_RST      16'h0000
`define CPP_WORD_RST      32'h0000_0000
`define CPP_CNT_RST       16'h0000

`endif

// ### cp_prim_pkg.sv
// types shared by the busy and null primitive sequencer
package cp_prim_pkg;

  // ==================================================================
  // sequencer states, gray coded along read, decide, pass, service
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_READ   = 3'h1,
    ST_DECIDE = 3'h3,
    ST_PASSPC = 3'h2,
    ST_IRQ    = 3'h6
  } seq_state_t;

  // ==================================================================
  // which interface register a transfer targets
  typedef enum logic {
    SEL_RESPONSE  = 1'b0,
    SEL_INSTR_ADR = 1'b1
  } cir_sel_t;

endpackage

// ### cpbn_checker.sv
// assertion checker for the busy and null primitive sequencer
`timescale 1ns/1ns
`include "cp_prim_map.svh"
module cpbn_checker (
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  input wire logic                  start,
  input wire logic                  start_cond,
  input wire logic                  start_bkpt,
  input wire logic                  trace_pending,
  input wire logic                  int_pending,
  input wire logic                  cir_req,
  input wire logic                  cir_we,
  input wire cp_prim_pkg::cir_sel_t cir_sel,
  input wire logic                  cir_ack,
  input wire logic [15:0]           cir_rdata,
  input wire logic                  irq_svc_req,
  input wire logic                  irq_svc_mid,
  input wire logic                  irq_svc_done,
  input wire logic                  restart,
  input wire logic                  bkpt_repeat,
  input wire logic                  complete,
  input wire logic                  cond_true,
  input wire logic                  trace_req,
  input wire logic                  busy
);
  import cp_prim_pkg::*;
  logic cond_q, bkpt_q, rd, bsy, nul;
  // ======================================================
  // kind of instruction is only seen with start, so keep it
  always_ff @(posedge core_clk) begin
    if (start && !busy) begin
      cond_q <= start_cond;
      bkpt_q <= start_bkpt;
    end
  end
  // decode the primitive word at the read acknowledge
  assign rd  = cir_req && cir_ack && !cir_we;
  assign bsy = rd && (cir_rdata[12:0] & `CPP_TYPE_MASK) == `CPP_BUSY_CODE;
  assign nul = rd && (cir_rdata[12:0] & `CPP_TYPE_MASK) == `CPP_NULL_CODE;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ======================================================
  // sequences and properties
  sequence s_busy; bsy && !cir_rdata[14]; endsequence
  sequence s_null(logic ca); nul && !cir_rdata[14] && cir_rdata[15] == ca;
  endsequence
  property p_pass; (bsy || nul) && cir_rdata[14]
    |-> ##2 cir_req && cir_we && cir_sel == SEL_INSTR_ADR; endproperty
  property p_busy_go; s_busy ##1 !int_pending
    |-> ##1 restart && !bkpt_repeat; endproperty
  property p_busy_irq; s_busy ##1 int_pending
    |-> ##1 irq_svc_req && !irq_svc_mid; endproperty
  property p_bkpt; irq_svc_done && irq_svc_req && !irq_svc_mid
    |-> ##1 restart && bkpt_repeat == bkpt_q; endproperty
  property p_mid; s_null(1'b1) ##0 cir_rdata[8] ##1 int_pending
    |-> ##1 irq_svc_req && irq_svc_mid; endproperty
  property p_reread; s_null(1'b1) ##0 !cir_rdata[8]
    |-> ##2 cir_req && !cir_we && !irq_svc_req; endproperty
  property p_cond;
    logic tf;
    (s_null(1'b0) ##0 (cond_q, tf = cir_rdata[0]))
      |-> ##2 complete && cond_true == tf;
  endproperty
  property p_gen;
    logic tr;
    s_null(1'b0) ##0 !cond_q && cir_rdata[1] ##1 (1'b1, tr = trace_pending)
      |-> ##1 complete && trace_req == tr;
  endproperty
  property p_trace; s_null(1'b0) ##0 !cond_q && !cir_rdata[1]
    ##1 trace_pending |-> ##1 !complete && (cir_req || irq_svc_req);
  endproperty
  a_pass: assert property (p_pass)
    else $error("pc not passed first");
  a_busy_go: assert property (p_busy_go)
    else $error("busy did not restart");
  a_busy_irq: assert property (p_busy_irq)
    else $error("busy missed preinstruction service");
  a_bkpt: assert property (p_bkpt)
    else $error("breakpoint repeat wrong");
  a_mid: assert property (p_mid)
    else $error("null missed midinstruction service");
  a_reread: assert property (p_reread)
    else $error("null did not reread at once");
  a_cond: assert property (p_cond)
    else $error("conditional completion wrong");
  a_gen: assert property (p_gen)
    else $error("general completion wrong");
  a_trace: assert property (p_trace)
    else $error("trace wait ended early");
endmodule
bind coproc_busy_null_primitive_handler cpbn_checker chk_u (.core_clk,
  .sys_rst, .start, .start_cond, .start_bkpt, .trace_pending, .int_pending,
  .cir_req, .cir_we, .cir_sel, .cir_ack, .cir_rdata, .irq_svc_req,
  .irq_svc_mid, .irq_svc_done, .restart, .bkpt_repeat, .complete,
  .cond_true, .trace_req, .busy);
